// ---- hdl/dram_init_pkg.sv ----
// constants, field layout and state codes for the dram reset/program/init block
package dram_init_pkg;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CORE_CLK_HZ      = 25_000_000;
   localparam int TICK_US          = 1;        // one refresh-clock tick
   localparam int TICK_CYCLES      = (CORE_CLK_HZ / 1_000_000) * TICK_US;
   localparam int FINE_SHORT_US    = 13;       // refresh interval, bit set
   localparam int FINE_LONG_US     = 15;       // refresh interval, bit clear
   localparam int INIT_TOGGLES     = 4096;     // RAS toggles in the init burst
   localparam int RESET_HOLD_EDGES = 16;

   // -------------------------------------------------------------------
   // programming word layout
   // -------------------------------------------------------------------
   localparam int PROG_W             = 23;
   localparam int ROW_W              = 10;
   localparam int ADDR_W             = 11;
   localparam int ROW_LSB            = 0;
   localparam int COL_LSB            = 10;
   localparam int BANK_LSB           = 20;
   localparam int LATCH_MODE_POS     = 20;     // bank bit 0
   localparam int ACCESS_MODE_POS    = 21;     // bank bit 1
   localparam int ECAS_SEL_POS       = 22;
   localparam int REFRESH_INTERVAL_POS = 13;   // column bit 3
   localparam int WAIT_LSB           = 0;      // wait-logic field
   localparam int WAIT_W             = 2;
   localparam logic [PROG_W-1:0] PROG_RESET = 23'h00_0000;

   typedef enum logic [2:0] {
      ST_UNPROG = 3'b001,
      ST_INIT   = 3'b010,
      ST_READY  = 3'b100
   } ctl_state_t;

endpackage

// ---- hdl/dram_ctrl_if.sv ----
// carrier between the top block, the init refresher and the access sequencer
`timescale 1ns/1ps
interface dram_ctrl_if;
   import dram_init_pkg::*;
   logic              refresh_interval;
   logic              start_init;
   logic              init_busy;
   logic              init_ras_n;
   logic [ADDR_W-1:0] init_row;
   logic              seq_enable;
   logic              access_mode;
   logic              ecas_sel;
   logic              req_n;
   logic              strobe_n;
   logic [3:0]        cas_ext_n;
   logic              acc_start;
   logic              acc_ras_n;
   logic [3:0]        acc_cas_n;

   modport top (output refresh_interval, start_init, seq_enable,
                access_mode, ecas_sel, req_n, strobe_n, cas_ext_n,
                input init_busy, init_ras_n, init_row, acc_start,
                acc_ras_n, acc_cas_n);
   modport refresher (input refresh_interval, start_init,
                      output init_busy, init_ras_n, init_row);
   modport sequencer (input seq_enable, access_mode, ecas_sel, req_n,
                      strobe_n, cas_ext_n,
                      output acc_start, acc_ras_n, acc_cas_n);
endinterface

// ---- hdl/init_refresher.sv ----
// timed refresh burst that runs once after the first programming
`timescale 1ns/1ps
module init_refresher
   import dram_init_pkg::*;
#(
   parameter int CLK_DIVISOR = TICK_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   dram_ctrl_if.refresher ctl
);
   logic [15:0] pre_reg;
   logic [3:0]  fine_reg;
   logic [11:0] tog_reg;
   logic        busy_reg;
   logic        ras_n_reg;
   logic [ADDR_W-1:0] row_reg;
   wire  logic  tick   = (pre_reg == 16'(CLK_DIVISOR - 1));
   wire  logic [3:0] fine_max = ctl.refresh_interval ?
                      4'(FINE_SHORT_US - 1) : 4'(FINE_LONG_US - 1);
   wire  logic  toggle = busy_reg & tick & (fine_reg == fine_max);
   wire  logic  last   = (tog_reg == 12'(INIT_TOGGLES - 1));

   // prescaler and fine-tune counters; period = divisor * fine tune
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_reg  <= 16'h0000;
         fine_reg <= 4'h0;
      end else if (ctl.start_init | tick) begin
         pre_reg  <= 16'h0000;
         fine_reg <= (ctl.start_init | (fine_reg == fine_max)) ?
                     4'h0 : fine_reg + 4'h1;
      end else begin
         pre_reg  <= pre_reg + 16'h0001;
      end
   end

   // burst: RAS toggles, row advances after each refresh low phase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_reg  <= 1'b0;
         ras_n_reg <= 1'b1;
         tog_reg   <= 12'h000;
         row_reg   <= 11'h000;
      end else if (ctl.start_init) begin
         busy_reg  <= 1'b1;
         ras_n_reg <= 1'b1;
         tog_reg   <= 12'h000;
         row_reg   <= 11'h000;
      end else if (toggle) begin
         ras_n_reg <= last ? 1'b1 : ~ras_n_reg;
         tog_reg   <= tog_reg + 12'h001;
         busy_reg  <= ~last;
         if (!ras_n_reg) begin
            row_reg <= row_reg + 11'h001;
         end
      end
   end

   assign ctl.init_busy  = busy_reg;
   assign ctl.init_ras_n = ras_n_reg;
   assign ctl.init_row   = row_reg;
endmodule // init_refresher

// ---- hdl/access_sequencer.sv ----
// port access RAS/CAS sequencing for both access modes
`timescale 1ns/1ps
module access_sequencer
   import dram_init_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   dram_ctrl_if.sequencer ctl
);
   logic       ale_reg;
   logic       ras_reg;
   logic [3:0] cas_reg;
   wire  logic mode1_go = ctl.seq_enable & ctl.access_mode
                        & ~ctl.strobe_n & ~ctl.req_n;
   wire  logic ale_seen = ctl.seq_enable & ~ctl.access_mode & ctl.strobe_n;
   wire  logic ras_on   = ras_reg | mode1_go;

   // latch-enable latch and held RAS; request release ends the access
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ale_reg <= 1'b0;
         ras_reg <= 1'b0;
      end else begin
         ale_reg <= ale_seen | (ale_reg & ~ras_reg);
         if (ctl.req_n & ~ale_seen) begin
            ras_reg <= 1'b0;
         end else if (ale_reg | mode1_go) begin
            ras_reg <= 1'b1;
         end
      end
   end

   // per-output CAS: set after RAS, release with RAS or with extend input
   for (genvar i = 0; i < 4; i++) begin : g_cas
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            cas_reg[i] <= 1'b0;
         end else if (ctl.ecas_sel) begin
            cas_reg[i] <= ~ctl.cas_ext_n[i] & (ras_on | cas_reg[i]);
         end else begin
            cas_reg[i] <= ras_on & ~ctl.req_n;
         end
      end
   end

   assign ctl.acc_start = ras_on & ~ras_reg;
   assign ctl.acc_ras_n = ~ras_on;
   assign ctl.acc_cas_n = ~cas_reg;
endmodule // access_sequencer

// ---- hdl/dram_init_ctrl.sv ----
// dram controller reset detection, programming register and init control
`timescale 1ns/1ps
module dram_init_ctrl
   import dram_init_pkg::*;
#(
   parameter int CLK_DIVISOR = TICK_CYCLES   // cycles per refresh tick
) (
   input  wire logic              CORE_CLK_I,
   input  wire logic              RST_I,
   input  wire logic              MODE_LOAD_STROBE_N_I,
   input  wire logic              REFRESH_DISABLE_N_I,
   input  wire logic              CHIP_SELECT_N_I,
   input  wire logic              ACCESS_REQUEST_N_I,
   input  wire logic              ADDRESS_STROBE_N_I,
   input  wire logic              WRITE_N_I,
   input  wire logic [ROW_W-1:0]  ROW_ADDR_IN_I,
   input  wire logic [ROW_W-1:0]  COL_ADDR_IN_I,
   input  wire logic [1:0]        BANK_I,
   input  wire logic [3:0]        CAS_EXTEND_IN_N_I,
   output logic [3:0]             RAS_N_O,
   output logic [3:0]             CAS_N_O,
   output logic                   WE_N_O,
   output logic                   REFRESH_IN_PROGRESS_N_O,
   output logic                   TRANSFER_ACK_N_O,
   output logic [ADDR_W-1:0]      DRAM_ADDR_O,
   output logic [1:0]             BANK_O,
   output logic [WAIT_W-1:0]      WAIT_CONFIG_O,
   output logic                   PROGRAMMED_O
);

   // -------------------------------------------------------------------
   // internal state
   // -------------------------------------------------------------------
   dram_ctrl_if ctl ();

   ctl_state_t        state_reg;
   ctl_state_t        state_next;
   logic [4:0]        hold_cnt_reg;
   logic              ml_q_reg;
   logic              dis_q_reg;
   logic [PROG_W-1:0] shadow_reg;
   logic [PROG_W-1:0] prog_reg;
   logic [WAIT_W-1:0] wait_reg;
   logic              wait_applied_reg;
   logic              start_init_reg;
   logic [ROW_W-1:0]  row_lat_reg;
   logic [ROW_W-1:0]  col_lat_reg;
   logic [1:0]        bank_lat_reg;
   logic              cas_phase_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic [1:0]        bank_reg;

   // -------------------------------------------------------------------
   // external reset detection
   // -------------------------------------------------------------------
   // both strobes low together count toward the reset; any break restarts
   // the count so a short overlap during normal programming is harmless
   wire logic both_low   = ~MODE_LOAD_STROBE_N_I & ~REFRESH_DISABLE_N_I;
   wire logic hold_full  = (hold_cnt_reg == 5'(RESET_HOLD_EDGES - 1));
   wire logic soft_reset = both_low & hold_full;

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         hold_cnt_reg <= 5'h00;
      end else if (!both_low) begin
         hold_cnt_reg <= 5'h00;
      end else if (!hold_full) begin
         hold_cnt_reg <= hold_cnt_reg + 5'h01;
      end
   end

   // -------------------------------------------------------------------
   // programming word capture
   // -------------------------------------------------------------------
   // previous-cycle levels of both strobes, for release and ordering
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ml_q_reg  <= 1'b1;
         dis_q_reg <= 1'b1;
      end else begin
         ml_q_reg  <= MODE_LOAD_STROBE_N_I;
         dis_q_reg <= REFRESH_DISABLE_N_I;
      end
   end

   // the word is sampled every cycle the strobe is low, so the value that
   // stood in the last cycle before release is the one that is loaded
   wire logic [PROG_W-1:0] live_word = {CAS_EXTEND_IN_N_I[0], BANK_I,
                                        COL_ADDR_IN_I, ROW_ADDR_IN_I};

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         shadow_reg <= PROG_RESET;
      end else if (!MODE_LOAD_STROBE_N_I) begin
         shadow_reg <= live_word;
      end
   end

   // release of mode-load; refresh-disable must already have been high
   // on the previous edge, otherwise this is only the end of a reset
   wire logic ml_release = ~ml_q_reg & MODE_LOAD_STROBE_N_I;
   wire logic ordered    = dis_q_reg;
   // a load is refused while the init burst is refreshing
   wire logic commit     = ml_release & ordered & ~ctl.init_busy;

   // programming register: holds until the next load or reset
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         prog_reg <= PROG_RESET;
      end else if (soft_reset) begin
         prog_reg <= PROG_RESET;
      end else if (commit) begin
         prog_reg <= shadow_reg;
      end
   end

   // -------------------------------------------------------------------
   // chip-selected programming access
   // -------------------------------------------------------------------
   // with mode-load low, a chip-selected request loads the wait field at
   // once and is answered one cycle later; the rest waits for release
   wire logic cs_prog = ~MODE_LOAD_STROBE_N_I & ~CHIP_SELECT_N_I
                      & ~ACCESS_REQUEST_N_I;

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wait_reg         <= '0;
         wait_applied_reg <= 1'b0;
      end else if (soft_reset) begin
         wait_reg         <= '0;
         wait_applied_reg <= 1'b0;
      end else begin
         wait_applied_reg <= cs_prog;
         if (cs_prog) begin
            wait_reg <= ROW_ADDR_IN_I[WAIT_LSB +: WAIT_W];
         end else if (commit) begin
            wait_reg <= shadow_reg[WAIT_LSB +: WAIT_W];
         end
      end
   end

   // acknowledge only after the wait field has taken effect
   assign TRANSFER_ACK_N_O = ~(cs_prog & wait_applied_reg);
   assign WAIT_CONFIG_O    = wait_reg;

   // -------------------------------------------------------------------
   // control state machine
   // -------------------------------------------------------------------
   // only a load from the unprogrammed state opens the init burst; loads
   // from the ready state keep it closed until the next reset
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_UNPROG: begin
            if (commit) begin
               state_next = ST_INIT;
            end
         end
         ST_INIT: begin
            if (!start_init_reg && !ctl.init_busy) begin
               state_next = ST_READY;
            end
         end
         ST_READY: begin
            state_next = ST_READY;
         end
         default: begin
            state_next = ST_UNPROG;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_reg      <= ST_UNPROG;
         start_init_reg <= 1'b0;
      end else if (soft_reset) begin
         state_reg      <= ST_UNPROG;
         start_init_reg <= 1'b0;
      end else begin
         state_reg      <= state_next;
         start_init_reg <= (state_reg == ST_UNPROG) & commit;
      end
   end

   wire logic in_init  = (state_reg == ST_INIT);
   wire logic is_ready = (state_reg == ST_READY);
   assign PROGRAMMED_O = ~(state_reg == ST_UNPROG);

   // -------------------------------------------------------------------
   // field decode and links to the leaf modules
   // -------------------------------------------------------------------
   wire logic latch_mode_bit       = prog_reg[LATCH_MODE_POS];
   wire logic access_mode_bit      = prog_reg[ACCESS_MODE_POS];
   wire logic cas_extend_select    = prog_reg[ECAS_SEL_POS];
   wire logic refresh_interval_bit = prog_reg[REFRESH_INTERVAL_POS];

   assign ctl.refresh_interval = refresh_interval_bit;
   assign ctl.start_init       = start_init_reg;
   // accesses run only once programmed and outside a programming cycle
   assign ctl.seq_enable       = is_ready & MODE_LOAD_STROBE_N_I;
   assign ctl.access_mode      = access_mode_bit;
   assign ctl.ecas_sel         = cas_extend_select;
   assign ctl.req_n            = ACCESS_REQUEST_N_I;
   assign ctl.strobe_n         = ADDRESS_STROBE_N_I;
   assign ctl.cas_ext_n        = CAS_EXTEND_IN_N_I;

   init_refresher #(
      .CLK_DIVISOR (CLK_DIVISOR)
   ) u_refresher (
      .clk_i (CORE_CLK_I),
      .rst_i (RST_I),
      .ctl   (ctl.refresher)
   );

   access_sequencer u_sequencer (
      .clk_i (CORE_CLK_I),
      .rst_i (RST_I),
      .ctl   (ctl.sequencer)
   );

   // -------------------------------------------------------------------
   // address latches
   // -------------------------------------------------------------------
   // latch mode 0 freezes the inputs at acc_start, which only fires in access mode 1; latch mode 1 lets
   // them flow straight through, so the host must hold them stable
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         row_lat_reg  <= '0;
         col_lat_reg  <= '0;
         bank_lat_reg <= 2'h0;
      end else if (ctl.acc_start) begin
         row_lat_reg  <= ROW_ADDR_IN_I;
         col_lat_reg  <= COL_ADDR_IN_I;
         bank_lat_reg <= BANK_I;
      end
   end

   wire logic [ROW_W-1:0] row_eff  = latch_mode_bit ? ROW_ADDR_IN_I
                                                    : row_lat_reg;
   wire logic [ROW_W-1:0] col_eff  = latch_mode_bit ? COL_ADDR_IN_I
                                                    : col_lat_reg;
   wire logic [1:0]       bank_eff = latch_mode_bit ? BANK_I
                                                    : bank_lat_reg;

   // -------------------------------------------------------------------
   // dram address outputs
   // -------------------------------------------------------------------
   // column is driven once any CAS of the access is low
   wire logic any_cas = ~(&ctl.acc_cas_n);

   always_comb begin
      if (in_init) begin
         addr_next = ctl.init_row;
      end else if (any_cas | cas_phase_reg) begin
         addr_next = {1'b0, col_eff};
      end else begin
         addr_next = {1'b0, row_eff};
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cas_phase_reg <= 1'b0;
         addr_reg      <= '0;
         bank_reg      <= 2'h0;
      end else begin
         cas_phase_reg <= ~ctl.acc_ras_n & ~in_init;
         addr_reg      <= addr_next;
         bank_reg      <= bank_eff;
      end
   end

   assign DRAM_ADDR_O = addr_reg;
   assign BANK_O      = bank_reg;

   // -------------------------------------------------------------------
   // strobe outputs
   // -------------------------------------------------------------------
   // the init burst owns RAS and keeps CAS high; refresh never extends CAS
   assign RAS_N_O = in_init ? {4{ctl.init_ras_n}}
                            : {4{ctl.acc_ras_n}};
   assign CAS_N_O = in_init ? 4'hF
                            : ctl.acc_cas_n;

   assign REFRESH_IN_PROGRESS_N_O = ~(in_init & ctl.init_busy);

   // refresh request (low while the burst runs) when CAS extend is selected, else write enable
   wire logic refresh_request_out_n = ~ctl.init_busy;
   assign WE_N_O = cas_extend_select ? refresh_request_out_n
                                     : WRITE_N_I;

endmodule // dram_init_ctrl

// ---- testbench/dram_init_ctrl_asserts.sv ----
// port assertions for the reset, programming and init block
`timescale 1ns/1ps
module dram_init_ctrl_asserts
   import dram_init_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic MODE_LOAD_STROBE_N_I,
   input wire logic REFRESH_DISABLE_N_I,
   input wire logic CHIP_SELECT_N_I,
   input wire logic ACCESS_REQUEST_N_I,
   input wire logic [ROW_W-1:0] ROW_ADDR_IN_I,
   input wire logic [3:0] CAS_N_O,
   input wire logic REFRESH_IN_PROGRESS_N_O,
   input wire logic [ADDR_W-1:0] DRAM_ADDR_O,
   input wire logic [WAIT_W-1:0] WAIT_CONFIG_O,
   input wire logic TRANSFER_ACK_N_O,
   input wire logic PROGRAMMED_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   logic [4:0] low_cnt_reg;
   // edges with both reset strobes low; saturates so it never wraps
   always_ff @(posedge CORE_CLK_I or posedge RST_I)
      if (RST_I) low_cnt_reg <= '0;
      else if (MODE_LOAD_STROBE_N_I || REFRESH_DISABLE_N_I) low_cnt_reg <= '0;
      else if (low_cnt_reg != 5'd31) low_cnt_reg <= low_cnt_reg + 5'd1;
   // strobe released while refresh-disable was still high or low
   sequence s_rel;
      $rose(MODE_LOAD_STROBE_N_I);
   endsequence
   sequence s_cs;
      !MODE_LOAD_STROBE_N_I && !CHIP_SELECT_N_I && !ACCESS_REQUEST_N_I;
   endsequence
   property p_cas; !REFRESH_IN_PROGRESS_N_O |-> CAS_N_O == 4'hF; endproperty
   a_cas: assert property (p_cas) else $error("cas low in init");
   property p_row0; $fell(REFRESH_IN_PROGRESS_N_O) |-> DRAM_ADDR_O == '0;
   endproperty
   a_row0: assert property (p_row0) else $error("init row");
   property p_start; $rose(PROGRAMMED_O) |-> ##2 !REFRESH_IN_PROGRESS_N_O;
   endproperty
   a_start: assert property (p_start) else $error("no init");
   property p_soft; low_cnt_reg >= 5'd16 |-> !PROGRAMMED_O; endproperty
   a_soft: assert property (p_soft) else $error("soft reset");
   property p_refuse; s_rel ##0 !$past(REFRESH_DISABLE_N_I) && !PROGRAMMED_O
      |=> !PROGRAMMED_O; endproperty
   a_refuse: assert property (p_refuse) else $error("reset programmed");
   property p_load; s_rel ##0 $past(REFRESH_DISABLE_N_I) &&
      REFRESH_IN_PROGRESS_N_O |=> PROGRAMMED_O; endproperty
   a_load: assert property (p_load) else $error("load lost");
   property p_wait; s_cs |=> WAIT_CONFIG_O == $past(ROW_ADDR_IN_I[1:0]);
   endproperty
   a_wait: assert property (p_wait) else $error("wait bits");
   property p_ack; s_cs ##1 s_cs |-> !TRANSFER_ACK_N_O; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
endmodule // dram_init_ctrl_asserts
bind dram_init_ctrl dram_init_ctrl_asserts i_dram_init_ctrl_asserts (.*);

// ---- testbench/dram_array_model.sv ----
// dram array stand-in that follows the init refresh rows
`timescale 1ns/1ps
module dram_array_model
   import dram_init_pkg::*;
(
   input wire logic clk_i,
   input wire logic [3:0] ras_n_i,
   input wire logic refresh_in_progress_n_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   output int rows_o,
   output int bad_o
);
   logic prev_ras;
   initial begin
      rows_o = 0;
      bad_o = 0;
   end
   // sampled on the falling clock so design updates have settled
   always @(negedge clk_i) begin
      if (!refresh_in_progress_n_n_i && prev_ras && !ras_n_i[0]) begin
         if (addr_i !== rows_o[ADDR_W-1:0]) bad_o++;
         rows_o++;
      end
      prev_ras = ras_n_i[0];
   end
endmodule // dram_array_model

// ---- testbench/tb_dram_init_ctrl.sv ----
// self-checking bench for the reset, programming and init block
`timescale 1ns/1ps
module tb_dram_init_ctrl;
   import dram_init_pkg::*;
   localparam int DIV = 1; // short tick keeps the burst inside the run
   logic clk = 0, rst = 1, ml_n = 1, dis_n = 1, cs_n = 1, access_request_n_n = 1;
   logic strb_n = 1, wr_n = 1, we_n, refresh_in_progress_n_n, ack_n, prog;
   logic [9:0] row = '0, col = '0;
   logic [1:0] bank = '0, bank_o, wait_o;
   logic [3:0] ext_n = 4'hF, ras_n, cas_n;
   logic [ADDR_W-1:0] addr;
   logic [22:0] w;
   int failures = 0, tests_run = 0, cyc = 0, rows, bad, n;
   dram_init_ctrl #(.CLK_DIVISOR(DIV)) i_dram_init_ctrl (
      .CORE_CLK_I(clk), .RST_I(rst), .MODE_LOAD_STROBE_N_I(ml_n),
      .REFRESH_DISABLE_N_I(dis_n), .CHIP_SELECT_N_I(cs_n),
      .ACCESS_REQUEST_N_I(access_request_n_n), .ADDRESS_STROBE_N_I(strb_n),
      .WRITE_N_I(wr_n), .ROW_ADDR_IN_I(row), .COL_ADDR_IN_I(col),
      .BANK_I(bank), .CAS_EXTEND_IN_N_I(ext_n), .RAS_N_O(ras_n),
      .CAS_N_O(cas_n), .WE_N_O(we_n), .REFRESH_IN_PROGRESS_N_O(refresh_in_progress_n_n),
      .TRANSFER_ACK_N_O(ack_n), .DRAM_ADDR_O(addr), .BANK_O(bank_o),
      .WAIT_CONFIG_O(wait_o), .PROGRAMMED_O(prog));
   dram_array_model i_dram_array_model (.clk_i(clk), .ras_n_i(ras_n),
      .refresh_in_progress_n_n_i(refresh_in_progress_n_n), .addr_i(addr), .rows_o(rows), .bad_o(bad));
   // 25 MHz clock and a ceiling well above the one init burst
   initial forever #20 clk = ~clk;
   always @(posedge clk) if (++cyc == 70000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
   end
   function automatic int init_len(logic iv);
      return INIT_TOGGLES * (iv ? FINE_SHORT_US : FINE_LONG_US) * DIV;
   endfunction
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         failures++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   // random word with the mode bits forced by the caller
   task automatic load(input logic [2:0] md, input bit cs);
      w = $urandom;
      w[13] = 1'b1;
      w[22:20] = md;
      ml_n = 0;
      {ext_n[0], bank, col, row} = w;
      if (cs) begin
         step(1); cs_n = 0; step(1); access_request_n_n = 0; step(1);
         chk(wait_o === w[1:0] && ack_n === 1'b0, "cs prog");
         access_request_n_n = 1; cs_n = 1;
      end
      step(1); ml_n = 1; step(1);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // reset, reset only, reset with program, init, reprogram and accesses
   initial begin
      w = $urandom(32'h0000_59fe);
      step(2); rst = 0; step(1);
      chk(prog === 1'b0 && refresh_in_progress_n_n === 1'b1 && cas_n === 4'hF, "rst");
      ml_n = 0; dis_n = 0; step(16); ml_n = 1; step(1); dis_n = 1; step(1);
      chk(prog === 1'b0, "reset only");
      ml_n = 0; dis_n = 0; step(16); dis_n = 1; load(3'b010, 0);
      chk(prog === 1'b1, "reset and program");
      for (n = 0; refresh_in_progress_n_n !== 1'b0 && n < 4; n++) step(1);
      for (n = 0; refresh_in_progress_n_n === 1'b0; n++) step(1);
      chk(n == init_len(1'b1), "init length");
      chk(rows == 2048 && bad == 0, "init rows");
      load(3'b010, 0); step(3);
      chk(refresh_in_progress_n_n === 1'b1, "init restarted");
      wr_n = $urandom; strb_n = 0; access_request_n_n = 0; #1;
      chk(ras_n === 4'h0, "mode 1 ras");
      step(1);
      chk(cas_n === 4'h0 && we_n === wr_n, "cas and we");
      // the held RAS flop drops on the edge that sees the request released
      access_request_n_n = 1; strb_n = 1; step(1);
      chk(ras_n === 4'hF, "ras end");
      chk(cas_n === 4'hF, "cas end");
      wr_n = 0; load(3'b110, 1);
      chk(we_n === 1'b1, "refresh request");
      ext_n = 4'b1010; strb_n = 0; access_request_n_n = 0; step(2);
      access_request_n_n = 1; strb_n = 1; step(1);
      chk(cas_n === 4'b1010, "cas extend");
      ext_n = 4'hF; step(1);
      chk(cas_n === 4'hF, "cas extend end");
      // access mode 0: the shared pin is a latch enable that idles low
      strb_n = 0; load(3'b000, 0);
      access_request_n_n = 0; strb_n = 1; step(1); strb_n = 0;
      chk(ras_n === 4'hF, "ale early ras");
      step(1);
      chk(ras_n === 4'h0, "mode 0 ras");
      access_request_n_n = 1; step(1);
      chk(ras_n === 4'hF, "mode 0 end");
      complete_run();
   end
endmodule // tb_dram_init_ctrl
